// *** src/thm_defs.svh ***
`ifndef THM_DEFS_SVH
`define THM_DEFS_SVH

// System clock rate in MHz.
`define THM_CLK_MHZ        100
// Network line loss and recovery.
`define THM_LOS_ZERO_RUN   175
`define THM_DENS_WIN       64
`define THM_DENS_PCT_X10   125
`define THM_DENS_MIN_ONES  ((`THM_DENS_WIN * `THM_DENS_PCT_X10 + 999) / 1000)
// Frame loss: errors among the last sync bits.
`define THM_OOF_WIN        4
`define THM_OOF_ERR_MIN    2
// Unframed ones run taken as an alarm indication.
`define THM_AIS_ONES_RUN   1024
// Health poll period and idle time before the automatic view.
`define THM_POLL_S         10
`define THM_POLL_CYC       (64'd1000000 * `THM_CLK_MHZ * `THM_POLL_S)
`define THM_IDLE_MIN       5
`define THM_IDLE_CYC       (64'd60000000 * `THM_CLK_MHZ * `THM_IDLE_MIN)
// Fault and self-test code width.
`define THM_CODE_W         32

`endif

// *** src/thm_pkg.sv ***
`default_nettype none
`include "thm_defs.svh"

package thm_pkg;

  // Conditions in priority order, highest first.
  typedef enum logic [3:0] {
    COND_NET_LOS,
    COND_NET_OOF,
    COND_NET_AIS,
    COND_NET_EER,
    COND_NET_YELLOW,
    COND_MASTER_CLK,
    COND_PORT_OOF,
    COND_PORT_EER,
    COND_MGMT_DOWN,
    COND_SELFTEST,
    COND_SW_FAULT,
    COND_DOWNLOAD,
    COND_TEST,
    COND_OPERATIONAL
  } thm_cond_t;

  typedef enum logic [3:0] {
    POST_PASS,
    POST_PROCESSOR,
    POST_CHIP,
    POST_LINE_LOS,
    POST_ALARM,
    POST_MEMORY,
    POST_NET_LOOP,
    POST_PORT_LOOP,
    POST_PORT_CIRCUIT,
    POST_UNKNOWN_EXP,
    POST_CODE
  } thm_post_t;

  typedef enum logic [1:0] {
    CLK_SRC_NET,
    CLK_SRC_PORT,
    CLK_SRC_INT
  } thm_clk_src_t;

  // Field order matches priority; the first field is the top bit.
  typedef struct packed {
    logic net_los;
    logic net_oof;
    logic net_ais;
    logic net_eer;
    logic net_yellow;
    logic master_clk;
    logic port_oof;
    logic port_eer;
    logic mgmt_down;
    logic selftest;
    logic sw_fault;
    logic download;
    logic test;
  } thm_flags_t;

  typedef struct packed {
    logic                    valid;
    logic [`THM_CODE_W-1:0]  code;
  } thm_code_t;

endpackage : thm_pkg

`default_nettype wire

// *** src/thm_los_det.sv ***
`default_nettype none
`include "thm_defs.svh"

// Loss-of-signal detector on the received network bit stream.
module thm_los_det
  import thm_pkg::*;
#(
  parameter int ZERO_RUN  = `THM_LOS_ZERO_RUN,
  parameter int WIN       = `THM_DENS_WIN,
  parameter int MIN_ONES  = `THM_DENS_MIN_ONES
)(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_bit_valid,
  input  wire logic i_bit,
  output var  logic o_los
);

  logic [8:0] zero_run;
  logic [7:0] win_cnt;
  logic [7:0] ones_cnt;
  logic       win_end;

  assign win_end = (win_cnt == 8'(WIN - 1));

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      zero_run <= 9'h000;
    else if (i_bit_valid)
      zero_run <= i_bit ? 9'h000 : ((zero_run == 9'(ZERO_RUN)) ? zero_run : zero_run + 9'h001);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      win_cnt  <= 8'h00;
      ones_cnt <= 8'h00;
    end
    else if (i_bit_valid)
    begin
      win_cnt  <= win_end ? 8'h00 : win_cnt + 8'h01;
      ones_cnt <= win_end ? 8'h00 : ones_cnt + 8'(i_bit);
    end
  end

  // A completed run of zeros sets the alarm; set wins over recovery.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_los <= 1'b0;
    else if (i_bit_valid && !i_bit && zero_run == 9'(ZERO_RUN - 1))
      o_los <= 1'b1;
    else if (i_bit_valid && win_end && (ones_cnt + 8'(i_bit)) >= 8'(MIN_ONES))
      o_los <= 1'b0;
  end

  chk_los_zero_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_bit_valid && !i_bit && zero_run == 9'(ZERO_RUN - 1)) |=> o_los)
    else $error("Loss of signal not declared after the zero run.");

  chk_los_recovery: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_los) |-> $past(i_bit_valid && win_end && (ones_cnt + 8'(i_bit)) >= 8'(MIN_ONES))
                     || !$past(i_rst_n))
    else $error("Loss of signal cleared outside a density window end.");

endmodule : thm_los_det

`default_nettype wire

// *** src/thm_health_mon.sv ***
`default_nettype none
`include "thm_defs.svh"

// Functional notes
// - Declare network loss after 175 zeros.
// - Clear loss at 12.5 percent ones density.
// - Frame loss on two of four errors.
// - Hold frame loss until reframe occurs.
// - Flag unframed all ones as alarm indication.
// - Network error rate flag with threshold hysteresis.
// - Flag yellow while far end sends it.
// - Net or port source failure flags; any failure selects internal clock.
// - Port conditions only with embedded link.
// - Port error clears below its threshold.
// - Poll every ten seconds, update on change.
// - Fixed priority order of all conditions.
// - Operational only when nothing else active.
// - Five idle minutes enter automatic status view.
// - Latch software fault and code until clear.
// - Latch interrupted download until reset.
// - Management link down when configured and unreachable.
// - Test status while any test runs.
// - Self-test failure status, details kept apart.
// - Self-test reports exactly one outcome.
// - Self-test checks checksum and both loops.
module thm_health_mon
  import thm_pkg::*;
#(
  parameter int          BER_W        = 16,
  parameter int          AIS_RUN      = `THM_AIS_ONES_RUN,
  parameter logic [35:0] POLL_CYCLES  = 36'(`THM_POLL_CYC),
  parameter logic [35:0] IDLE_CYCLES  = 36'(`THM_IDLE_CYC)
)(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_rx_valid,
  input  wire logic                    i_rx_bit,
  input  wire logic                    i_fsync_valid,
  input  wire logic                    i_fsync_err,
  input  wire logic                    i_reframe,
  input  wire logic [BER_W-1:0]        i_net_ber,
  input  wire logic [BER_W-1:0]        i_net_ber_thresh,
  input  wire logic                    i_yellow_rx,
  input  wire thm_clk_src_t            i_clk_src,
  input  wire logic                    i_clk_src_fail,
  input  wire logic                    i_embedded_port_link,
  input  wire logic                    i_port_oof_det,
  input  wire logic [BER_W-1:0]        i_port_ber,
  input  wire logic [BER_W-1:0]        i_port_ber_thresh,
  input  wire logic                    i_com_mgmt_cfg,
  input  wire logic                    i_mgmt_comm_ok,
  input  wire logic                    i_post_done,
  input  wire logic                    i_post_cksum_ok,
  input  wire logic                    i_post_net_loop_ok,
  input  wire logic                    i_post_port_loop_ok,
  input  wire thm_post_t               i_post_other,
  input  wire logic [`THM_CODE_W-1:0]  i_post_code,
  input  wire logic                    i_sw_fault,
  input  wire logic [`THM_CODE_W-1:0]  i_sw_fault_code,
  input  wire logic                    i_sw_fault_clear,
  input  wire logic                    i_dl_active,
  input  wire logic                    i_dl_abort,
  input  wire logic                    i_test_active,
  input  wire logic                    i_key_activity,
  output var  thm_clk_src_t            o_timing_src,
  output var  thm_flags_t              o_flags,
  output var  thm_cond_t               o_health_status_view,
  output var  logic                    o_auto_view,
  output var  thm_post_t               o_self_test_result_view,
  output var  logic [`THM_CODE_W-1:0]  o_self_test_code,
  output var  thm_code_t               o_internal_software_fault
);

  function automatic thm_cond_t top_cond(input thm_flags_t f);
    logic [12:0] v;
    thm_cond_t   c;
    v = f;
    c = COND_OPERATIONAL;
    for (int i = 0; i < 13; i++)
    begin
      if (v[i])
        c = thm_cond_t'(4'(12 - i));
    end
    return c;
  endfunction

  logic            net_los;
  logic [2:0]      fsync_hist;
  logic [2:0]      next_err_cnt;
  logic            net_oof;
  logic [10:0]     ones_run;
  logic            net_ais;
  logic            net_eer;
  logic            net_yellow;
  logic            master_clk;
  logic            port_oof;
  logic            port_eer;
  logic            mgmt_down;
  logic            selftest;
  logic            download;
  logic            test;
  thm_flags_t      live;
  thm_flags_t      snap;
  logic [35:0]     poll_cnt;
  logic            poll_tick;
  logic [35:0]     idle_cnt;
  thm_post_t       next_post;

  thm_los_det #(
    .ZERO_RUN (`THM_LOS_ZERO_RUN),
    .WIN      (`THM_DENS_WIN),
    .MIN_ONES (`THM_DENS_MIN_ONES)
  ) u_los (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_bit_valid (i_rx_valid),
    .i_bit       (i_rx_bit),
    .o_los       (net_los)
  );

  always_comb
  begin
    next_err_cnt = 3'(i_fsync_err);
    for (int i = 0; i < `THM_OOF_WIN - 1; i++)
      next_err_cnt = next_err_cnt + 3'(fsync_hist[i]);
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_reframe)
      fsync_hist <= 3'h0;
    else if (i_fsync_valid)
      fsync_hist <= {fsync_hist[1:0], i_fsync_err};
  end

  // A new frame loss wins over a reframe in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      net_oof <= 1'b0;
    else if (i_fsync_valid && next_err_cnt >= 3'(`THM_OOF_ERR_MIN))
      net_oof <= 1'b1;
    else if (i_reframe)
      net_oof <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ones_run <= 11'h000;
    else if (i_rx_valid)
      ones_run <= !i_rx_bit ? 11'h000 : ((ones_run == 11'(AIS_RUN)) ? ones_run : ones_run + 11'h001);
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      net_ais <= 1'b0;
    else
      net_ais <= net_oof && (ones_run == 11'(AIS_RUN));
  end

  // Hold the flag while the rate equals the threshold.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      net_eer <= 1'b0;
    else if (i_net_ber > i_net_ber_thresh)
      net_eer <= 1'b1;
    else if (i_net_ber < i_net_ber_thresh)
      net_eer <= 1'b0;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      net_yellow <= 1'b0;
    else
      net_yellow <= i_yellow_rx;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      master_clk   <= 1'b0;
      o_timing_src <= CLK_SRC_INT;
    end
    else
    begin
      master_clk   <= i_clk_src_fail && (i_clk_src != CLK_SRC_INT);
      o_timing_src <= i_clk_src_fail ? CLK_SRC_INT : i_clk_src;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      port_oof <= 1'b0;
      port_eer <= 1'b0;
    end
    else
    begin
      port_oof <= i_embedded_port_link && i_port_oof_det;
      if (!i_embedded_port_link)
        port_eer <= 1'b0;
      else if (i_port_ber > i_port_ber_thresh)
        port_eer <= 1'b1;
      else if (i_port_ber < i_port_ber_thresh)
        port_eer <= 1'b0;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      mgmt_down <= 1'b0;
    else
      mgmt_down <= i_com_mgmt_cfg && !i_mgmt_comm_ok;
  end

  // Built-in checks take precedence over the other reported outcome.
  always_comb
  begin
    if (!i_post_cksum_ok)
      next_post = POST_MEMORY;
    else if (!i_post_net_loop_ok)
      next_post = POST_NET_LOOP;
    else if (!i_post_port_loop_ok)
      next_post = POST_PORT_LOOP;
    else
      next_post = i_post_other;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_self_test_result_view <= POST_PASS;
      o_self_test_code        <= '0;
      selftest                <= 1'b0;
    end
    else if (i_post_done)
    begin
      o_self_test_result_view <= next_post;
      o_self_test_code        <= (next_post == POST_CODE) ? i_post_code : '0;
      selftest                <= (next_post != POST_PASS);
    end
  end

  // A new fault wins over a clear in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_internal_software_fault <= '0;
    else if (i_sw_fault)
      o_internal_software_fault <= '{valid: 1'b1, code: i_sw_fault_code};
    else if (i_sw_fault_clear)
      o_internal_software_fault <= '0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      download <= 1'b0;
    else if (i_dl_active && i_dl_abort)
      download <= 1'b1;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      test <= 1'b0;
    else
      test <= i_test_active;
  end

  assign live = '{net_los: net_los, net_oof: net_oof, net_ais: net_ais,
                  net_eer: net_eer, net_yellow: net_yellow, master_clk: master_clk,
                  port_oof: port_oof, port_eer: port_eer, mgmt_down: mgmt_down,
                  selftest: selftest, sw_fault: o_internal_software_fault.valid,
                  download: download, test: test};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_flags <= '0;
    else
      o_flags <= live;
  end

  assign poll_tick = (poll_cnt == POLL_CYCLES - 36'h1);
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      poll_cnt <= 36'h0;
    else
      poll_cnt <= poll_tick ? 36'h0 : poll_cnt + 36'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      snap                 <= '0;
      o_health_status_view <= COND_OPERATIONAL;
    end
    else if (poll_tick && live != snap)
    begin
      snap                 <= live;
      o_health_status_view <= top_cond(live);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_key_activity)
      idle_cnt <= 36'h0;
    else if (idle_cnt != IDLE_CYCLES)
      idle_cnt <= idle_cnt + 36'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_auto_view <= 1'b0;
    else
      o_auto_view <= !i_key_activity && (idle_cnt == IDLE_CYCLES - 36'h1 || o_auto_view);
  end

  sequence s_oof_errs;
    i_fsync_valid && next_err_cnt >= 3'(`THM_OOF_ERR_MIN);
  endsequence
  sequence s_dl_broken;
    i_dl_active && i_dl_abort;
  endsequence
  chk_oof_declare: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_oof_errs |=> net_oof)
    else $error("Frame loss not declared after two sync errors.");
  chk_oof_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(net_oof) |-> $past(i_reframe) || !$past(i_rst_n))
    else $error("Frame loss cleared without a reframe.");
  chk_ais_framed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    net_ais |-> $past(net_oof))
    else $error("Alarm indication raised on a framed signal.");
  chk_eer_thresh: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_net_ber != i_net_ber_thresh) |=> net_eer == $past(i_net_ber > i_net_ber_thresh))
    else $error("Network error flag did not follow the threshold.");
  chk_clk_fallback: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    master_clk |-> o_timing_src == CLK_SRC_INT)
    else $error("Clock failure without fallback to internal timing.");
  chk_port_link: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_embedded_port_link |=> !port_oof && !port_eer)
    else $error("Port condition raised with the embedded link off.");
  chk_fault_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_internal_software_fault.valid && !i_sw_fault_clear) |=> o_internal_software_fault.valid)
    else $error("Software fault dropped without a clear.");
  chk_dl_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_dl_broken ##1 1'b1 [*3] |-> download)
    else $error("Download failure did not stay latched.");
  chk_view_update: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (poll_tick && live != snap) |=> o_health_status_view == top_cond($past(live)))
    else $error("Polled view is not the top condition.");
  chk_view_steady: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !poll_tick |=> $stable(o_health_status_view))
    else $error("View changed between polls.");
  chk_auto_view: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_key_activity |=> !o_auto_view)
    else $error("Automatic view held through key activity.");

endmodule : thm_health_mon

`default_nettype wire

// *** verif/thm_t1_line.sv ***
`default_nettype none

// Behavioural network line: received bit stream and frame sync checks.
module thm_t1_line
  import thm_pkg::*;
(
  input  wire logic i_clk,
  output var  logic o_rx_valid,
  output var  logic o_rx_bit,
  output var  logic o_fsync_valid,
  output var  logic o_fsync_err
);
  timeunit 1ns;
  timeprecision 1ps;

  logic busy = 1'b0;

  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_bit = 1'b0;
    o_fsync_valid = 1'b0;
    o_fsync_err = 1'b0;
  end

  // Idle data lines toggle so a stale value never passes for traffic.
  always @(posedge i_clk)
  begin
    if (!busy)
    begin
      o_rx_bit <= ~o_rx_bit;
      o_fsync_err <= ~o_fsync_err;
    end
  end

  // Sends n bits, cycling through the pattern from its low bit.
  task automatic send_bits(input int n, input logic [7:0] pat);
    busy = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      o_rx_valid = 1'b1;
      o_rx_bit = pat[i % 8];
      @(posedge i_clk);
      #1;
    end
    o_rx_valid = 1'b0;
    busy = 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  // Sends n checked sync bits; a set bit of errs marks one received in error.
  task automatic send_sync(input int n, input logic [7:0] errs);
    busy = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      o_fsync_valid = 1'b1;
      o_fsync_err = errs[i % 8];
      @(posedge i_clk);
      #1;
    end
    o_fsync_valid = 1'b0;
    busy = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
endmodule // thm_t1_line

`default_nettype wire

// *** verif/tb_thm_health_mon.sv ***
`default_nettype none
`include "thm_defs.svh"

module tb_thm_health_mon
  import thm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  wire  i_rx_valid, i_rx_bit, i_fsync_valid, i_fsync_err;
  logic i_reframe, i_yellow_rx, i_clk_src_fail, i_embedded_port_link, i_port_oof_det, i_com_mgmt_cfg;
  logic i_mgmt_comm_ok, i_post_done, i_post_cksum_ok, i_post_net_loop_ok, i_post_port_loop_ok;
  logic i_sw_fault, i_sw_fault_clear, i_dl_active, i_dl_abort, i_test_active, i_key_activity;
  logic [15:0] i_net_ber, i_net_ber_thresh, i_port_ber, i_port_ber_thresh, thr;
  logic [`THM_CODE_W-1:0] i_post_code, i_sw_fault_code, o_self_test_code;
  logic [31:0] lfsr = 32'h0e85;
  thm_clk_src_t i_clk_src, o_timing_src;
  thm_post_t i_post_other, o_self_test_result_view;
  thm_flags_t o_flags, exp_f, last_f;
  thm_cond_t o_health_status_view;
  logic o_auto_view;
  thm_code_t o_internal_software_fault;
  thm_flags_t notes[$];
  int fails = 0;
  int checked = 0;
  logic mon_on = 1'b0;

  thm_health_mon #(.AIS_RUN(8), .POLL_CYCLES(36'h10), .IDLE_CYCLES(36'h14)) u_dut (.*);

  thm_t1_line u_line (.i_clk(i_clk), .o_rx_valid(i_rx_valid), .o_rx_bit(i_rx_bit),
                      .o_fsync_valid(i_fsync_valid), .o_fsync_err(i_fsync_err));

  always #5 i_clk = ~i_clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  // Changes one condition, then lets several polls pass before reading the view.
  task automatic raise(ref logic s, input logic v, input thm_cond_t c, input thm_cond_t view);
    exp_f[12 - c] = v;
    notes.push_back(exp_f);
    s = v;
    step(40);
    chk("health view", view, o_health_status_view);
  endtask

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Every change of the flags, seen mid-cycle, takes the oldest expected value off the queue.
  always @(negedge i_clk)
  begin
    if (mon_on && o_flags !== last_f)
    begin
      if (notes.size() == 0)
      begin
        fails++;
        $display("[FAIL] o_flags expected no change seen %h", o_flags);
      end
      else
        chk("o_flags", notes.pop_front(), o_flags);
    end
    last_f = o_flags;
  end

  initial
  begin
    repeat (5000) @(posedge i_clk);
    fails++;
    $display("[FAIL] watchdog expected end seen hang");
    summarize();
  end

  initial
  begin
    {i_reframe, i_yellow_rx, i_clk_src_fail, i_embedded_port_link, i_port_oof_det, i_com_mgmt_cfg, i_mgmt_comm_ok,
     i_post_done, i_sw_fault, i_sw_fault_clear, i_dl_active, i_dl_abort, i_test_active, i_key_activity} = '0;
    {i_post_cksum_ok, i_post_net_loop_ok, i_post_port_loop_ok} = 3'b111;
    {i_net_ber, i_net_ber_thresh, i_port_ber, i_port_ber_thresh, i_post_code, i_sw_fault_code} = '0;
    i_clk_src = CLK_SRC_NET;
    i_post_other = POST_PASS;
    exp_f = '0;
    step(6);
    i_rst_n = 1'b1;
    step(2);
    mon_on = 1'b1;
    chk("reset view", COND_OPERATIONAL, o_health_status_view);
    chk("timing source", CLK_SRC_NET, o_timing_src);
    pulse(i_post_done);
    step(2);
    chk("self test pass", POST_PASS, o_self_test_result_view);
    exp_f.selftest = 1'b1;
    notes.push_back(exp_f);
    for (int k = 0; k < 13; k++)
    begin
      {i_post_cksum_ok, i_post_net_loop_ok, i_post_port_loop_ok} = k < 3 ? ~(3'b111 >> k) : 3'b111;
      i_post_other = thm_post_t'(k < 3 ? 10 : k - 2);
      lfsr = next_rand(lfsr);
      i_post_code = lfsr;
      pulse(i_post_done);
      step(2);
      chk("self test view", k < 3 ? 5 + k : k - 2, o_self_test_result_view);
      chk("self test code", k == 12 ? lfsr : 0, o_self_test_code);
    end
    {i_post_cksum_ok, i_post_net_loop_ok, i_post_port_loop_ok} = 3'b111;
    i_post_other = POST_PASS;
    exp_f.selftest = 1'b0;
    notes.push_back(exp_f);
    pulse(i_post_done);
    step(2);
    chk("self test clear", POST_PASS, o_self_test_result_view);
    $display("test self test done");
    u_line.send_bits(174, 8'h00);
    u_line.send_bits(1, 8'hff);
    exp_f.net_los = 1'b1;
    notes.push_back(exp_f);
    u_line.send_bits(175, 8'h00);
    step(3);
    exp_f.net_los = 1'b0;
    notes.push_back(exp_f);
    u_line.send_bits(128, 8'h01);
    step(3);
    chk("los cleared", 0, o_flags.net_los);
    $display("test signal loss done");
    exp_f.net_oof = 1'b1;
    notes.push_back(exp_f);
    u_line.send_sync(8, 8'b0101_0001);
    exp_f.net_ais = 1'b1;
    notes.push_back(exp_f);
    u_line.send_bits(16, 8'hff);
    step(2);
    exp_f.net_ais = 1'b0;
    notes.push_back(exp_f);
    u_line.send_bits(1, 8'h00);
    step(3);
    chk("oof held", 1, o_flags.net_oof);
    exp_f.net_oof = 1'b0;
    notes.push_back(exp_f);
    pulse(i_reframe);
    step(3);
    $display("test framing done");
    lfsr = next_rand(lfsr);
    thr = {1'b0, lfsr[14:1], 1'b1};
    i_net_ber_thresh = thr;
    i_net_ber = thr;
    step(3);
    exp_f.net_eer = 1'b1;
    notes.push_back(exp_f);
    i_net_ber = thr + 16'h0001;
    step(3);
    i_net_ber = thr;
    step(3);
    chk("net rate hold", 1, o_flags.net_eer);
    exp_f.net_eer = 1'b0;
    notes.push_back(exp_f);
    i_net_ber = thr - 16'h0001;
    step(3);
    lfsr = next_rand(lfsr);
    thr = {1'b0, lfsr[14:1], 1'b1};
    i_port_ber_thresh = thr;
    i_port_ber = thr + 16'h0001;
    i_port_oof_det = 1'b1;
    step(3);
    chk("port flags off", 0, {o_flags.port_oof, o_flags.port_eer});
    {exp_f.port_oof, exp_f.port_eer} = 2'b11;
    notes.push_back(exp_f);
    i_embedded_port_link = 1'b1;
    step(3);
    i_port_ber = thr;
    step(3);
    chk("port rate hold", 1, o_flags.port_eer);
    exp_f.port_eer = 1'b0;
    notes.push_back(exp_f);
    i_port_ber = thr - 16'h0001;
    step(3);
    exp_f.port_oof = 1'b0;
    notes.push_back(exp_f);
    i_embedded_port_link = 1'b0;
    step(3);
    i_port_oof_det = 1'b0;
    $display("test error rate done");
    raise(i_test_active, 1'b1, COND_TEST, COND_TEST);
    raise(i_com_mgmt_cfg, 1'b1, COND_MGMT_DOWN, COND_MGMT_DOWN);
    raise(i_yellow_rx, 1'b1, COND_NET_YELLOW, COND_NET_YELLOW);
    raise(i_clk_src_fail, 1'b1, COND_MASTER_CLK, COND_NET_YELLOW);
    chk("timing fallback", CLK_SRC_INT, o_timing_src);
    raise(i_yellow_rx, 1'b0, COND_NET_YELLOW, COND_MASTER_CLK);
    raise(i_clk_src_fail, 1'b0, COND_MASTER_CLK, COND_MGMT_DOWN);
    raise(i_com_mgmt_cfg, 1'b0, COND_MGMT_DOWN, COND_TEST);
    raise(i_test_active, 1'b0, COND_TEST, COND_OPERATIONAL);
    i_clk_src = CLK_SRC_PORT;
    step(3);
    chk("timing port", CLK_SRC_PORT, o_timing_src);
    $display("test priority done");
    lfsr = next_rand(lfsr);
    i_sw_fault_code = lfsr;
    exp_f.sw_fault = 1'b1;
    notes.push_back(exp_f);
    pulse(i_sw_fault);
    i_sw_fault_code = ~lfsr;
    step(3);
    chk("fault latch", {1'b1, lfsr}, o_internal_software_fault);
    exp_f.sw_fault = 1'b0;
    notes.push_back(exp_f);
    pulse(i_sw_fault_clear);
    step(3);
    i_dl_active = 1'b1;
    exp_f.download = 1'b1;
    notes.push_back(exp_f);
    pulse(i_dl_abort);
    i_dl_active = 1'b0;
    pulse(i_sw_fault_clear);
    step(3);
    exp_f.sw_fault = 1'b1;
    notes.push_back(exp_f);
    pulse(i_sw_fault);
    step(3);
    exp_f = '0;
    notes.push_back(exp_f);
    i_rst_n = 1'b0;
    step(2);
    i_rst_n = 1'b1;
    step(3);
    chk("fault after reset", 0, o_internal_software_fault);
    $display("test latches done");
    pulse(i_key_activity);
    step(10);
    chk("auto view early", 0, o_auto_view);
    step(15);
    chk("auto view idle", 1, o_auto_view);
    pulse(i_key_activity);
    chk("auto view key", 0, o_auto_view);
    $display("test auto view done");
    step(5);
    if (notes.size() != 0)
    begin
      fails++;
      $display("[FAIL] flag notes expected 0 seen %0d", notes.size());
    end
    summarize();
  end
endmodule // tb_thm_health_mon

`default_nettype wire
